//--- include/rctx_cfg.svh
// rctx_cfg.svh: option field positions, register offsets and timing counts
// assumes a 100 MHz ref_clk and a plain word-wide register port
`ifndef RCTX_CFG_SVH
`define RCTX_CFG_SVH
`define RCTX_CLK_MHZ        100
`define RCTX_ADDR_CFG       4'h0
`define RCTX_ADDR_SERIAL    4'h1
`define RCTX_ADDR_COUNT     4'h2
`define RCTX_ADDR_STATUS    4'h3
`define RCTX_ADDR_MASK      4'h4
`define RCTX_ADDR_KEY1      4'h5
`define RCTX_ADDR_KEY2      4'h6
`define RCTX_ADDR_LOAD      4'h7
`define RCTX_F_CNT20        0
`define RCTX_F_OVF_EN       1
`define RCTX_F_HDR_SHORT    2
`define RCTX_F_VSEL_HI      3
`define RCTX_F_VLATCH       4
`define RCTX_F_SHUTOFF      5
`define RCTX_F_WAKE_EN      6
`define RCTX_F_FSK          7
`define RCTX_F_DUAL         8
`define RCTX_F_RFEN         9
`define RCTX_F_SER28        10
`define RCTX_F_BLINK1       11
`define RCTX_F_MOD_LO       12
`define RCTX_F_TE_LO        14
`define RCTX_F_GUARD_LO     16
`define RCTX_F_MINCW_LO     18
`define RCTX_F_LED_LO       20
`define RCTX_F_WAKE_LO      22
`define RCTX_TE_BASE_US     100
`define RCTX_HDR_LONG_TE    10
`define RCTX_HDR_SHORT_TE   4
`define RCTX_GUARD_BASE_TE  16
`define RCTX_WAKE_BASE_TE   8
`define RCTX_SHUTOFF_MS     3200
`define RCTX_LED_BASE_MS    50
`define RCTX_WORD_BITS      66
`define RCTX_OVF_RESET      2'h3
`define RCTX_CFG_RESET      32'h00000000
`define RCTX_EV_TXDONE      0
`define RCTX_EV_LOWBAT      1
`define RCTX_EV_SHUTOFF     2
`define RCTX_EV_OVF         3
`endif

//--- include/rctx_pkg.sv
// rctx_pkg: types shared by the rolling-code transmitter
// assumes rctx_cfg.svh is on the include path
package rctx_pkg;
  typedef enum logic [1:0] {RCTX_PWM, RCTX_MANCH, RCTX_VARIABLE_PULSE_WIDTH_FORMAT, RCTX_PPM} rctx_mod_t;
  typedef struct packed {
    logic [1:0] wake_len;
    logic [1:0] led_on;
    logic [1:0] min_cw;
    logic [1:0] guard;
    logic [1:0] te_sel;
    rctx_mod_t  mod;
    logic       blink_once;
    logic       ser28;
    logic       rf_en;
    logic       dual;
    logic       fsk;
    logic       wake_en;
    logic       shutoff;
    logic       vlatch;
    logic       vsel_hi;
    logic       hdr_short;
    logic       ovf_en;
    logic       cnt20;
  } rctx_opt_t;
  typedef struct packed {
    logic        rf_enable;
    logic        data;
  } rctx_rf_t;
endpackage

//--- hw/rctx_top.sv
// rctx_top: option-controlled code-word transmitter of a rolling-code encoder
// assumes synchronous button inputs and comparator flags; regs over a plain port
// Behaviour
// - sync counter is 16 or 20 bits wide by option.
// - overflow option clears one overflow bit per counter wrap, never sets again.
// - header option shortens sync header from ten to four pulse periods.
// - low voltage flag set when supply below selected 2.2 or 3.2 V threshold.
// - latch option holds low battery indication until power cycle.
// - auto shutoff stops transmission after fixed continuous time.
// - brief press still sends at least the minimum code words.
// - optional wake-up preamble before first word, length and pulse width by option.
// - option orders RF enable and data activation for ASK or FSK.
// - dual mode uses third button pin as sub-encoder select.
// - RF enable option drives third pin high while sending outside dual mode, still read as button when idle.
// - four modulation formats: PWM, Manchester, variable PWM, PPM.
// - all elements timed from selectable basic pulse period.
// - selectable guard time inserted between code words.
// - blink-once option blinks LED once on low battery, on-time selectable.
// - serial number 32 or 28 bits, placed in fixed code portion.
// - two keys stored, active sub-encoder key used.
`timescale 1ns/1ns
`include "rctx_cfg.svh"
module rctx_top
  import rctx_pkg::*;
#(
  parameter int SHUTOFF_CYC = `RCTX_SHUTOFF_MS * 1000 * `RCTX_CLK_MHZ,
  parameter int LED_CYC     = `RCTX_LED_BASE_MS * 1000 * `RCTX_CLK_MHZ,
  parameter int TE_CYC      = `RCTX_TE_BASE_US * `RCTX_CLK_MHZ
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [2:0]  buttons,
  input  wire logic        below_2v2,
  input  wire logic        below_3v2,
  output logic             third_button_pin_o,
  output logic             third_button_pin_oe,
  output logic             rf_enable,
  output logic             rf_data,
  output logic             led,
  output logic             sub_encoder2,
  output logic             low_voltage_flag,
  output logic             irq
);
  rctx_opt_t   opt_shadow;
  rctx_opt_t   opt;
  logic [31:0] serial;
  logic [31:0] key1;
  logic [31:0] key2;
  logic [19:0] sync_cnt;
  logic [1:0]  ovf_bits;
  logic [3:0]  status;
  logic [3:0]  mask;
  logic        loaded;
  logic        lowbat_latched;
  logic        led_done;
  logic        sub_sel;
  logic [31:0] te_cnt;
  logic [31:0] run_cnt;
  logic [31:0] led_cnt;
  logic [7:0]  phase;
  logic [6:0]  bit_idx;
  logic [3:0]  words_sent;
  logic        shut;
  logic        data_lvl;
  logic [65:0] word;
  typedef enum logic [2:0] {S_IDLE, S_LEAD, S_WAKE, S_HDR, S_BITS, S_GUARD} rctx_st_t;
  rctx_st_t st;

  function automatic logic [31:0] te_mult(input logic [1:0] sel);
    te_mult = TE_CYC * (32'h1 << sel);
  endfunction

  // while the device drives the third pin it reads its own drive, so that input is ignored
  wire        pressed     = |{buttons[2] & ~third_button_pin_oe, buttons[1:0]};
  wire        sel_btn3    = opt.dual;
  wire [2:0]  fn_code     = sel_btn3 ? {1'b0, buttons[1:0]} : buttons;
  wire        volt_low    = opt.vsel_hi ? below_3v2 : below_2v2;
  wire        lowbat_now  = volt_low | (opt.vlatch & lowbat_latched);
  wire [31:0] te_len      = te_mult(opt.te_sel);
  wire        te_tick     = (te_cnt == te_len - 32'h1);
  wire [7:0]  hdr_len     = opt.hdr_short ? 8'(`RCTX_HDR_SHORT_TE) : 8'(`RCTX_HDR_LONG_TE);
  wire [7:0]  guard_len   = 8'(`RCTX_GUARD_BASE_TE) << opt.guard;
  wire [7:0]  wake_len    = 8'(`RCTX_WAKE_BASE_TE) << opt.wake_len;
  wire [3:0]  min_words   = 4'h1 << opt.min_cw;
  wire [31:0] ser_fix     = opt.ser28 ? {4'h0, serial[27:0]} : serial;
  wire [31:0] act_key     = sub_sel ? key2 : key1;
  wire [19:0] cnt_word    = opt.cnt20 ? sync_cnt : {4'h0, sync_cnt[15:0]};
  wire [31:0] hop         = {fn_code[1:0], ovf_bits, 8'h00, cnt_word} ^ act_key;
  wire        wrap        = opt.cnt20 ? (sync_cnt == 20'hFFFFF) : (sync_cnt[15:0] == 16'hFFFF);
  wire        start_tx    = (st == S_IDLE) & pressed & ~shut & loaded;
  wire        bit_val     = word[bit_idx];
  wire [7:0]  sub_cnt     = phase;
  wire [3:0]  ev_set      = {wrap & start_tx & opt.ovf_en, shut & (st != S_IDLE),
                             start_tx & lowbat_now, (st == S_GUARD) & te_tick & (phase == 8'h0)};
  wire        wr_status   = wr & (addr == `RCTX_ADDR_STATUS);

  // element level per modulation format, each bit spans three pulse periods
  always_comb begin
    data_lvl = 1'b0;
    case (st)
      S_WAKE:  data_lvl = opt.wake_len[0] ? ~phase[1] : ~phase[0];
      S_HDR:   data_lvl = 1'b0;
      S_BITS: begin
        case (opt.mod)
          RCTX_PWM:   data_lvl = (sub_cnt == 8'h0) | ((sub_cnt == 8'h1) & ~bit_val);
          RCTX_MANCH: data_lvl = (sub_cnt == 8'h0) ? bit_val : ~bit_val;
          RCTX_VARIABLE_PULSE_WIDTH_FORMAT:  data_lvl = (sub_cnt == 8'h0) | ((sub_cnt != 8'h2) & bit_val);
          RCTX_PPM:   data_lvl = bit_val ? (sub_cnt == 8'h2) : (sub_cnt == 8'h0);
          default:    data_lvl = 1'b0;
        endcase
      end
      default: data_lvl = 1'b0;
    endcase
  end

  always_comb begin
    word = {opt.cnt20, lowbat_now, ser_fix, hop};
  end

  // register port and interrupt
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      opt_shadow <= rctx_opt_t'(`RCTX_CFG_RESET);
      serial     <= 32'h00000000;
      key1       <= 32'h00000000;
      key2       <= 32'h00000000;
      mask       <= 4'h0;
      status     <= 4'h0;
      rdata      <= 32'h00000000;
    end else begin
      if (wr & (addr == `RCTX_ADDR_CFG)) opt_shadow <= rctx_opt_t'(wdata[23:0]);
      if (wr & (addr == `RCTX_ADDR_SERIAL)) serial <= wdata;
      if (wr & (addr == `RCTX_ADDR_KEY1)) key1 <= wdata;
      if (wr & (addr == `RCTX_ADDR_KEY2)) key2 <= wdata;
      if (wr & (addr == `RCTX_ADDR_MASK)) mask <= wdata[3:0];
      status <= (status & ~(wr_status ? wdata[3:0] : 4'h0)) | ev_set;
      rdata <= 32'h00000000;
      if (rd) begin
        case (addr)
          `RCTX_ADDR_CFG:    rdata <= {8'h00, opt};
          `RCTX_ADDR_SERIAL: rdata <= serial;
          `RCTX_ADDR_COUNT:  rdata <= {10'h000, ovf_bits, cnt_word};
          `RCTX_ADDR_STATUS: rdata <= {28'h0, status};
          `RCTX_ADDR_MASK:   rdata <= {28'h0, mask};
          `RCTX_ADDR_LOAD:   rdata <= {31'h0, loaded};
          default:           rdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) irq <= 1'b0;
    else     irq <= |(status & mask);
  end

  // option load; frozen copy is only refreshed when idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      opt    <= rctx_opt_t'(`RCTX_CFG_RESET);
      loaded <= 1'b0;
    end else if (wr & (addr == `RCTX_ADDR_LOAD)) begin
      loaded <= 1'b1;
    end else if (st == S_IDLE) begin
      opt <= opt_shadow;
    end
  end

  // counter with overflow bits; ovf bits only ever clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_cnt <= 20'h00000;
      ovf_bits <= `RCTX_OVF_RESET;
    end else if (wr & (addr == `RCTX_ADDR_COUNT)) begin
      sync_cnt <= wdata[19:0];
    end else if (start_tx) begin
      sync_cnt <= opt.cnt20 ? sync_cnt + 20'h1 : {4'h0, sync_cnt[15:0] + 16'h1};
      if (wrap & opt.ovf_en) ovf_bits <= {1'b0, ovf_bits[1]};
    end
  end

  // transmit sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= S_IDLE;
      te_cnt <= 32'h0;
      phase <= 8'h0;
      bit_idx <= 7'h0;
      words_sent <= 4'h0;
      sub_sel <= 1'b0;
    end else begin
      te_cnt <= (st == S_IDLE || te_tick) ? 32'h0 : te_cnt + 32'h1;
      case (st)
        S_IDLE: begin
          words_sent <= 4'h0;
          phase <= 8'h0;
          if (start_tx) begin
            sub_sel <= opt.dual & buttons[2];
            st <= S_LEAD;
          end
        end
        S_LEAD: if (te_tick) begin
          st <= opt.wake_en ? S_WAKE : S_HDR;
          phase <= 8'h0;
        end
        S_WAKE: if (te_tick) begin
          phase <= phase + 8'h1;
          if (phase == wake_len - 8'h1) begin
            st <= S_HDR;
            phase <= 8'h0;
          end
        end
        S_HDR: if (te_tick) begin
          phase <= phase + 8'h1;
          if (phase == hdr_len - 8'h1) begin
            st <= S_BITS;
            phase <= 8'h0;
            bit_idx <= 7'h0;
          end
        end
        S_BITS: if (te_tick) begin
          phase <= (phase == 8'h2) ? 8'h0 : phase + 8'h1;
          if (phase == 8'h2) begin
            bit_idx <= bit_idx + 7'h1;
            if (bit_idx == 7'(`RCTX_WORD_BITS - 1)) begin
              st <= S_GUARD;
              words_sent <= words_sent + 4'h1;
            end
          end
        end
        S_GUARD: if (te_tick) begin
          phase <= phase + 8'h1;
          if (phase == guard_len - 8'h1) begin
            phase <= 8'h0;
            if (shut) st <= S_IDLE;
            else if (pressed | (words_sent < min_words)) st <= S_HDR;
            else st <= S_IDLE;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // continuous-transmission timer; released only after buttons let go
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_cnt <= 32'h0;
      shut <= 1'b0;
    end else if (~pressed) begin
      run_cnt <= 32'h0;
      shut <= 1'b0;
    end else if (opt.shutoff & (st != S_IDLE)) begin
      if (run_cnt == SHUTOFF_CYC - 1) shut <= 1'b1;
      else run_cnt <= run_cnt + 32'h1;
    end
  end

  // low battery latch and led
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lowbat_latched <= 1'b0;
      led_done <= 1'b0;
      led_cnt <= 32'h0;
      led <= 1'b0;
      low_voltage_flag <= 1'b0;
    end else begin
      if (start_tx & volt_low) lowbat_latched <= 1'b1;
      if (start_tx) low_voltage_flag <= lowbat_now;
      if (led_cnt != 32'h0) begin
        led_cnt <= led_cnt - 32'h1;
        led <= 1'b1;
      end else begin
        led <= 1'b0;
        if (start_tx & ~(opt.blink_once & lowbat_now & led_done)) begin
          led_cnt <= LED_CYC << opt.led_on;
          if (lowbat_now) led_done <= 1'b1;
        end
      end
    end
  end

  // rf output sequencing: ASK raises enable with data, FSK raises enable a period early
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rf_enable <= 1'b0;
      rf_data <= 1'b0;
      third_button_pin_o <= 1'b0;
      third_button_pin_oe <= 1'b0;
      sub_encoder2 <= 1'b0;
    end else begin
      rf_enable <= opt.fsk ? (st != S_IDLE) : (st != S_IDLE) & (st != S_LEAD);
      rf_data <= (st == S_LEAD) ? 1'b0 : data_lvl;
      // pin drive is dropped while idle so the button can still be read
      third_button_pin_o <= opt.rf_en & (st != S_IDLE);
      third_button_pin_oe <= opt.rf_en & ~opt.dual & (st != S_IDLE);
      sub_encoder2 <= sub_sel;
    end
  end

  cnt_width_a: assert property (@(posedge ref_clk) disable iff (rst)
    !opt.cnt20 && start_tx |=> sync_cnt[19:16] == 4'h0) else $error("counter too wide");
  ovf_never_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    $past(!ovf_bits[1]) |-> !ovf_bits[1]) else $error("overflow bit set again");
  lowv_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
    start_tx && opt.vsel_hi && below_3v2 |=> low_voltage_flag) else $error("low_voltage_flag not set");
  latch_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    lowbat_latched |=> lowbat_latched) else $error("latch dropped");
  shut_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
    shut && st == S_IDLE |=> st == S_IDLE) else $error("tx after shutoff");
  min_word_a: assert property (@(posedge ref_clk) disable iff (rst)
    $past(st) == S_GUARD && st != S_GUARD && $past(words_sent < min_words)
    && !$past(shut) |-> st == S_HDR) else $error("min words short");
  fsk_order_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(rf_data) |-> rf_enable) else $error("data before enable");
  hdr_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    st == S_HDR |-> phase < hdr_len) else $error("header too long");
  guard_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    st == S_GUARD |-> phase < guard_len) else $error("guard overrun");
  opt_frozen_a: assert property (@(posedge ref_clk) disable iff (rst)
    st != S_IDLE && $past(st) != S_IDLE |-> $stable(opt)) else $error("opt changed");
endmodule

//--- dv/rctx_rf_model.sv
// rctx_rf_model: passive rf stage that tallies what the transmitter puts on air
// assumes rf_enable and rf_data are registered levels on ref_clk
`timescale 1ns/1ns
module rctx_rf_model (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic rf_enable,
  input  wire logic rf_data,
  output int        bursts,
  output int        on_cyc
);
  logic was_on;
  // counts keep running so the bench can compare differences between words
  always @(posedge ref_clk) begin
    if (rst) begin
      bursts <= 0;
      on_cyc <= 0;
      was_on <= 1'b0;
    end else begin
      was_on <= rf_enable;
      if (rf_enable && !was_on)
        bursts <= bursts + 1;
      if (rf_enable)
        on_cyc <= on_cyc + 1;
    end
  end
endmodule

//--- dv/rctx_top_tb.sv
// rctx_top_tb: random and corner-case bench for the code-word transmitter
// assumes shortened counts: four cycle pulse period, 2000 cycle shutoff
`timescale 1ns/1ns
`include "rctx_cfg.svh"
module rctx_top_tb;
  localparam int TE = 4;
  logic        ref_clk, rst, wr, rd, below_2v2, below_3v2;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, got, seed, rnd, seen;
  logic [2:0]  user_b, buttons;
  logic        pin_o, pin_oe, rf_enable, rf_data, led, sub2, lvf, irq, led_seen;
  int          mismatches, checked, cycles, n, d0, bursts, on_cyc;
  // the third pin reads back what the device drives while it drives it
  assign buttons = {pin_oe ? pin_o : user_b[2], user_b[1:0]};
  rctx_top #(.SHUTOFF_CYC(2000), .LED_CYC(20), .TE_CYC(TE)) rctx_top_i (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .buttons(buttons), .below_2v2(below_2v2), .below_3v2(below_3v2),
    .third_button_pin_o(pin_o), .third_button_pin_oe(pin_oe), .rf_enable(rf_enable),
    .rf_data(rf_data), .led(led), .sub_encoder2(sub2), .low_voltage_flag(lvf), .irq(irq));
  rctx_rf_model rctx_rf_model_i (.ref_clk(ref_clk), .rst(rst), .rf_enable(rf_enable),
    .rf_data(rf_data), .bursts(bursts), .on_cyc(on_cyc));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic exp_low(input logic hi, input logic b22, input logic b32);
    return hi ? b32 : b22;
  endfunction
  function automatic int exp_ovf(input int wraps);
    return (wraps >= 2) ? 0 : 2 - wraps;
  endfunction
  task automatic results();
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic setup(input logic [31:0] c);
    wr_reg(`RCTX_ADDR_CFG, c);
    wr_reg(`RCTX_ADDR_LOAD, 32'h1);
    seen = 32'h0;
    led_seen = 1'b0;
  endtask
  // press for hold cycles, then count finished words until the air goes quiet
  task automatic run_words(input logic [2:0] b, input int hold, output int cnt);
    int idle;
    cnt = 0;
    idle = 0;
    @(posedge ref_clk);
    user_b <= b;
    repeat (hold) @(posedge ref_clk);
    user_b <= 3'h0;
    // quiet means the carrier has been off for a while, not merely no interrupt
    while (idle < 300) begin
      @(posedge ref_clk);
      #1 idle++;
      if (led === 1'b1) led_seen = 1'b1;
      if (rf_enable === 1'b1) idle = 0;
      if (irq === 1'b1) begin
        rd_reg(`RCTX_ADDR_STATUS, got);
        seen = seen | got;
        if (got[`RCTX_EV_TXDONE] === 1'b1) cnt++;
        wr_reg(`RCTX_ADDR_STATUS, got);
        idle = 0;
      end
    end
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    seed = 32'h4B7E999A;
    {rst, wr, rd, below_2v2, below_3v2} = 5'h10;
    addr = 4'h0;
    wdata = 32'h0;
    user_b = 3'h0;
    {mismatches, checked, cycles} = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 check({pin_oe, rf_enable, led, sub2, lvf, irq}, 32'h0);
    rd_reg(`RCTX_ADDR_CFG, got);
    check(got, `RCTX_CFG_RESET);
    wr_reg(4'hF, $random(seed));
    rd_reg(4'hF, got);
    check(got, 32'h0);
    for (int k = 0; k < 3; k++) begin
      rnd = $random(seed);
      // keys are write-only and read back as zero
      wr_reg((k == 0) ? 4'(`RCTX_ADDR_SERIAL) : 4'(`RCTX_ADDR_KEY1 + k - 1), rnd);
      rd_reg((k == 0) ? 4'(`RCTX_ADDR_SERIAL) : 4'(`RCTX_ADDR_KEY1 + k - 1), got);
      check(got, (k == 0) ? rnd : 32'h0);
    end
    rd_reg(`RCTX_ADDR_SERIAL, rnd);
    wr_reg(`RCTX_ADDR_SERIAL, rnd + 32'h1);
    rd_reg(`RCTX_ADDR_SERIAL, got);
    check(got, rnd + 32'h1);
    wr_reg(`RCTX_ADDR_MASK, 32'h1);
    for (int m = 0; m < 4; m++) begin
      setup((m << `RCTX_F_MOD_LO) | ((m & 1) << `RCTX_F_FSK));
      d0 = bursts;
      rnd = $random(seed);
      run_words(3'h1 + rnd[1:0], 10, n);
      check(n, 1);
      check(bursts - d0, 1);
    end
    for (int mc = 0; mc < 3; mc++) begin
      setup(mc << `RCTX_F_MINCW_LO);
      run_words(3'h2, 3, n);
      check(n, 1 << mc);
    end
    for (int t = 0; t < 2; t++) begin
      setup(t << `RCTX_F_TE_LO);
      d0 = on_cyc;
      run_words(3'h1, 3, n);
      d0 = on_cyc - d0;
      setup((t << `RCTX_F_TE_LO) | (1 << `RCTX_F_HDR_SHORT));
      d0 = d0 + on_cyc;
      run_words(3'h1, 3, n);
      check(d0 - on_cyc, (6 * TE) << t);
    end
    for (int v = 0; v < 5; v++) begin
      rnd = (v == 4) ? 32'h0 : $random(seed);
      below_2v2 <= rnd[0];
      below_3v2 <= rnd[1];
      setup(v[0] << `RCTX_F_VSEL_HI);
      run_words(3'h1, 3, n);
      check(seen[`RCTX_EV_LOWBAT], exp_low(v[0], rnd[0], rnd[1]));
      check(lvf, exp_low(v[0], rnd[0], rnd[1]));
    end
    setup(1 << `RCTX_F_VLATCH);
    below_2v2 <= 1'b1;
    run_words(3'h1, 3, n);
    below_2v2 <= 1'b0;
    setup(1 << `RCTX_F_VLATCH);
    run_words(3'h1, 3, n);
    check(seen[`RCTX_EV_LOWBAT], 1'b1);
    // low battery already shown once since power-up, so blink-once keeps the led dark
    setup((1 << `RCTX_F_BLINK1) | (1 << `RCTX_F_VLATCH));
    run_words(3'h1, 3, n);
    check(led_seen, 1'b0);
    setup(32'h0);
    run_words(3'h1, 3, n);
    check(led_seen, 1'b1);
    setup(1 << `RCTX_F_SHUTOFF);
    run_words(3'h1, 4000, n);
    check(seen[`RCTX_EV_SHUTOFF], 1'b1);
    for (int k = 0; k < 2; k++) begin
      setup((1 << `RCTX_F_DUAL) | (k << `RCTX_F_RFEN));
      user_b <= {1'b1, 2'b01};
      repeat (80) @(posedge ref_clk);
      #1 check(sub2, 1'b1);
      check(pin_oe, 1'b0);
      run_words(3'h1, 1, n);
      setup(1 << `RCTX_F_RFEN);
      user_b <= 3'h1;
      repeat (80) @(posedge ref_clk);
      #1 check({pin_oe, pin_o, sub2}, 3'h6);
      run_words(3'h1, 1, n);
    end
    setup(1 << `RCTX_F_OVF_EN);
    got = 32'h0030FFFF;
    for (int w = 1; w < 4; w++) begin
      wr_reg(`RCTX_ADDR_COUNT, {got[31:20], 20'h0FFFF});
      run_words(3'h1, 3, n);
      rd_reg(`RCTX_ADDR_COUNT, got);
      check(got[19:0], 20'h0);
      check($countones(got[21:20]), exp_ovf(w));
    end
    setup(1 << `RCTX_F_CNT20);
    wr_reg(`RCTX_ADDR_COUNT, 32'h0000FFFF);
    run_words(3'h1, 3, n);
    rd_reg(`RCTX_ADDR_COUNT, got);
    check(got[19:0], 20'h10000);
    results();
  end
endmodule
